// ===== hdl/lcd_setting_decoder.sv
// Display-setting command decoder, device end of the link
`include "lcd_cmd_consts.svh"

module lcd_setting_decoder (
  input wire logic pclk,
  input wire logic presetn,
  lcd_cmd_if.dev link,
  input wire logic [1:0] pixel_code,
  input wire logic [6:0] ram_column,
  input wire logic [6:0] scan_step,
  output logic [7:0] line_count,
  output logic [4:0] inversion_line_field,
  output logic [2:0] bias_select_field,
  output logic [1:0] pump_factor_field,
  output logic [5:0] contrast_level_field,
  output logic column_mirror_bit,
  output logic row_order_bit,
  output logic all_on_bit,
  output logic invert_gray_bit,
  output logic panel_show_bit,
  output logic power_save,
  output logic osc_running,
  output logic charge_pump_stage_on,
  output logic regulator_stage_on,
  output logic follower_stage_on,
  output logic outputs_grounded,
  output logic [1:0] pixel_level,
  output logic [6:0] column_driver_line,
  output logic [6:0] row_driver_line,
  output logic data_valid,
  output logic [7:0] data_byte
);
  lcd_cmd_pkg::dec_state_t state_reg, state_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] count_reg, count_next;
  logic [2:0] pwr_cfg_reg, pwr_cfg_next;
  logic osc_enable_reg, osc_enable_next;
  logic [7:0] lines_reg, lines_next;
  logic [4:0] inv_reg, inv_next;
  logic [2:0] bias_reg, bias_next;
  logic [1:0] pump_reg, pump_next;
  logic [5:0] contrast_reg, contrast_next;
  logic mirror_reg, mirror_next;
  logic row_rev_reg, row_rev_next;
  logic all_on_reg, all_on_next;
  logic invert_reg, invert_next;
  logic show_reg, show_next;
  logic save_reg, save_next;
  logic [1:0] level_reg, level_next;
  logic [6:0] col_reg, col_next;
  logic [6:0] row_reg, row_next;
  logic valid_reg, valid_next;
  logic [7:0] dbyte_reg, dbyte_next;
  logic [2:0] stage_reg, stage_next;
  logic run_reg, run_next;
  logic is_data;
  logic [7:0] b;

  always_comb begin
    b = link.wr_byte;
    state_next = state_reg;
    op_next = op_reg;
    count_next = count_reg;
    pwr_cfg_next = pwr_cfg_reg;
    osc_enable_next = osc_enable_reg;
    lines_next = lines_reg;
    inv_next = inv_reg;
    bias_next = bias_reg;
    pump_next = pump_reg;
    contrast_next = contrast_reg;
    mirror_next = mirror_reg;
    row_rev_next = row_rev_reg;
    all_on_next = all_on_reg;
    invert_next = invert_reg;
    show_next = show_reg;
    save_next = save_reg;
    valid_next = 1'b0;
    dbyte_next = dbyte_reg;
    is_data = link.cmd_data_select && !link.three_wire_mode;
    if (link.wr_strobe) begin
      case (state_reg)
        lcd_cmd_pkg::ST_DATA: begin
          valid_next = 1'b1;
          dbyte_next = b;
          if (count_reg == 8'h00) begin
            state_next = lcd_cmd_pkg::ST_CMD;
          end else begin
            count_next = count_reg - 8'h01;
          end
        end
        lcd_cmd_pkg::ST_PARAM: begin
          state_next = lcd_cmd_pkg::ST_CMD;
          if (op_reg[7:2] == `OP_LINE_CNT_HI) begin
            if (b >= `LINE_CNT_MIN && b <= `LINE_CNT_MAX) begin
              lines_next = b;
            end
          end else if (op_reg[7:2] == `OP_INVERSION_HI) begin
            inv_next = b[`INV_FIELD_W-1:0];
          end else if (op_reg == `OP_CONTRAST) begin
            contrast_next = b[`CONTRAST_W-1:0];
          end else if (op_reg == `OP_DATA_LEN && link.three_wire_mode) begin
            count_next = b;
            state_next = lcd_cmd_pkg::ST_DATA;
          end
        end
        default: begin
          if (is_data) begin
            valid_next = 1'b1;
            dbyte_next = b;
          end else if (b[7:4] == `OP_TWO_BYTE_HI || b == `OP_CONTRAST ||
                       b[7:3] == `OP_GRAY_HI || b == `OP_DATA_LEN) begin
            op_next = b;
            state_next = lcd_cmd_pkg::ST_PARAM;
          end else if (b[7:3] == `OP_PWR_CFG_HI) begin
            pwr_cfg_next = b[2:0];
          end else if (b[7:3] == `OP_BIAS_HI) begin
            bias_next = b[2:0];
          end else if (b[7:2] == `OP_PUMP_HI) begin
            pump_next = b[1:0];
          end else if (b[7:1] == `OP_MIRROR_HI) begin
            mirror_next = b[0];
          end else if (b[7:4] == `OP_ROW_ORDER_HI) begin
            row_rev_next = b[`ROW_ORDER_POS];
          end else if (b[7:1] == `OP_ALL_ON_HI) begin
            all_on_next = b[0];
          end else if (b[7:1] == `OP_INVERT_HI) begin
            invert_next = b[0];
          end else if (b[7:1] == `OP_SHOW_HI) begin
            show_next = b[0];
          end else if (b == `OP_SAVE_ENTER) begin
            save_next = 1'b1;
          end else if (b == `OP_SAVE_EXIT) begin
            save_next = 1'b0;
          end else if (b == `OP_OSC_START) begin
            osc_enable_next = 1'b1;
          end else if (b == `OP_INV_CANCEL) begin
            inv_next = `INVERSION_RST;
          end else if (b == `OP_SOFT_RESET) begin
            contrast_next = `CONTRAST_RST;
            count_next = 8'h00;
          end
        end
      endcase
    end
  end

  // Panel view, stages and driver line mapping
  always_comb begin
    if (!show_reg || save_reg) begin
      level_next = `LEVEL_BLANK;
    end else if (all_on_reg) begin
      level_next = `LEVEL_LIT;
    end else if (invert_reg) begin
      level_next = ~pixel_code;
    end else begin
      level_next = pixel_code;
    end
    col_next = mirror_reg ? `COL_LAST - ram_column : ram_column;
    row_next = row_rev_reg ? `COL_LAST - scan_step : scan_step;
    stage_next = save_reg ? 3'h0 : pwr_cfg_reg;
    run_next = osc_enable_reg && !save_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= lcd_cmd_pkg::ST_CMD;
      op_reg <= 8'h00;
      count_reg <= 8'h00;
      pwr_cfg_reg <= 3'h0;
      osc_enable_reg <= 1'b0;
      lines_reg <= `LINE_CNT_RST;
      inv_reg <= `INVERSION_RST;
      bias_reg <= `BIAS_RST;
      pump_reg <= `PUMP_RST;
      contrast_reg <= `CONTRAST_RST;
      mirror_reg <= 1'b0;
      row_rev_reg <= 1'b0;
      all_on_reg <= 1'b0;
      invert_reg <= 1'b0;
      show_reg <= 1'b0;
      save_reg <= 1'b0;
      level_reg <= `LEVEL_BLANK;
      col_reg <= 7'h00;
      row_reg <= 7'h00;
      valid_reg <= 1'b0;
      dbyte_reg <= 8'h00;
      stage_reg <= 3'h0;
      run_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      count_reg <= count_next;
      pwr_cfg_reg <= pwr_cfg_next;
      osc_enable_reg <= osc_enable_next;
      lines_reg <= lines_next;
      inv_reg <= inv_next;
      bias_reg <= bias_next;
      pump_reg <= pump_next;
      contrast_reg <= contrast_next;
      mirror_reg <= mirror_next;
      row_rev_reg <= row_rev_next;
      all_on_reg <= all_on_next;
      invert_reg <= invert_next;
      show_reg <= show_next;
      save_reg <= save_next;
      level_reg <= level_next;
      col_reg <= col_next;
      row_reg <= row_next;
      valid_reg <= valid_next;
      dbyte_reg <= dbyte_next;
      stage_reg <= stage_next;
      run_reg <= run_next;
    end
  end

  assign line_count = lines_reg;
  assign inversion_line_field = inv_reg;
  assign bias_select_field = bias_reg;
  assign pump_factor_field = pump_reg;
  assign contrast_level_field = contrast_reg;
  assign column_mirror_bit = mirror_reg;
  assign row_order_bit = row_rev_reg;
  assign all_on_bit = all_on_reg;
  assign invert_gray_bit = invert_reg;
  assign panel_show_bit = show_reg;
  assign power_save = save_reg;
  assign outputs_grounded = save_reg;
  assign osc_running = run_reg;
  assign charge_pump_stage_on = stage_reg[2];
  assign regulator_stage_on = stage_reg[1];
  assign follower_stage_on = stage_reg[0];
  assign pixel_level = level_reg;
  assign column_driver_line = col_reg;
  assign row_driver_line = row_reg;
  assign data_valid = valid_reg;
  assign data_byte = dbyte_reg;
endmodule

// ===== hdl/lcd_cmd_consts.svh
// Opcodes, field positions, reset values and host register offsets
`ifndef LCD_CMD_CONSTS_SVH
`define LCD_CMD_CONSTS_SVH
`define OP_PWR_CFG_HI 5'h05
`define OP_TWO_BYTE_HI 4'h4
`define OP_LINE_CNT_HI 6'h12
`define OP_INVERSION_HI 6'h13
`define OP_BIAS_HI 5'h0a
`define OP_PUMP_HI 6'h19
`define OP_CONTRAST 8'h81
`define OP_GRAY_HI 5'h11
`define OP_MIRROR_HI 7'h50
`define OP_ROW_ORDER_HI 4'hc
`define OP_ALL_ON_HI 7'h52
`define OP_INVERT_HI 7'h53
`define OP_SAVE_ENTER 8'ha9
`define OP_SAVE_EXIT 8'he1
`define OP_OSC_START 8'hab
`define OP_SHOW_HI 7'h57
`define OP_SOFT_RESET 8'he2
`define OP_INV_CANCEL 8'he4
`define OP_DATA_LEN 8'he8
`define ROW_ORDER_POS 3
`define INV_FIELD_W 5
`define CONTRAST_W 6
`define LINE_CNT_MIN 8'h10
`define LINE_CNT_MAX 8'h80
`define LINE_CNT_RST 8'h80
`define INVERSION_RST 5'h00
`define BIAS_RST 3'h7
`define PUMP_RST 2'h0
`define CONTRAST_RST 6'h20
`define LEVEL_LIT 2'h3
`define LEVEL_BLANK 2'h0
`define COL_LAST 7'h7f
`define HOST_CMD_OFS 8'h00
`define HOST_DATA_OFS 8'h04
`define HOST_COUNT_OFS 8'h08
`define HOST_MODE_OFS 8'h0c
`endif

// ===== hdl/lcd_cmd_pkg.sv
// Types used by the decoder end of the command link
package lcd_cmd_pkg;
  typedef enum logic [1:0] {ST_CMD, ST_PARAM, ST_DATA} dec_state_t;
endpackage

// ===== hdl/lcd_cmd_if.sv
// Byte link between host controller and display decoder
interface lcd_cmd_if;
  logic wr_strobe;
  logic cmd_data_select;
  logic [7:0] wr_byte;
  logic three_wire_mode;
  modport host (
    output wr_strobe,
    output cmd_data_select,
    output wr_byte,
    output three_wire_mode
  );
  modport dev (
    input wr_strobe,
    input cmd_data_select,
    input wr_byte,
    input three_wire_mode
  );
endinterface

// ===== hdl/lcd_cmd_host.sv
// APB-controlled host end that writes command and data bytes
`include "lcd_cmd_consts.svh"

module lcd_cmd_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lcd_cmd_if.host link
);
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic strobe_reg, strobe_next;
  logic select_reg, select_next;
  logic [7:0] byte_reg, byte_next;
  logic mode_reg, mode_next;
  logic [15:0] sent_reg, sent_next;
  logic mapped;
  logic commit;

  always_comb begin
    mapped = paddr == `HOST_CMD_OFS || paddr == `HOST_DATA_OFS ||
             paddr == `HOST_COUNT_OFS || paddr == `HOST_MODE_OFS;
    commit = psel && penable && pready_reg;
    pready_next = psel && !penable;
    pslverr_next = psel && !penable && !mapped;
    prdata_next = prdata_reg;
    strobe_next = 1'b0;
    select_next = select_reg;
    byte_next = byte_reg;
    mode_next = mode_reg;
    sent_next = sent_reg;
    if (psel && !penable && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (paddr == `HOST_COUNT_OFS) begin
        prdata_next = {16'h0000, sent_reg};
      end else if (paddr == `HOST_MODE_OFS) begin
        prdata_next = {31'h0000_0000, mode_reg};
      end
    end
    if (commit && pwrite) begin
      if (paddr == `HOST_CMD_OFS || paddr == `HOST_DATA_OFS) begin
        strobe_next = 1'b1;
        select_next = paddr == `HOST_DATA_OFS;
        byte_next = pwdata[7:0];
        sent_next = sent_reg + 16'h0001;
      end else if (paddr == `HOST_MODE_OFS) begin
        mode_next = pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      strobe_reg <= 1'b0;
      select_reg <= 1'b0;
      byte_reg <= 8'h00;
      mode_reg <= 1'b0;
      sent_reg <= 16'h0000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      strobe_reg <= strobe_next;
      select_reg <= select_next;
      byte_reg <= byte_next;
      mode_reg <= mode_next;
      sent_reg <= sent_next;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign link.wr_strobe = strobe_reg;
  assign link.cmd_data_select = select_reg;
  assign link.wr_byte = byte_reg;
  assign link.three_wire_mode = mode_reg;
endmodule

// ===== tb/lcd_setting_asserts.sv
// Concurrent checks on the command link and decoder settings
module lcd_setting_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_strobe,
  input wire logic cmd_data_select,
  input wire logic [7:0] wr_byte,
  input wire logic three_wire_mode,
  input wire logic [7:0] line_count,
  input wire logic [4:0] inversion_line_field,
  input wire logic [2:0] bias_select_field,
  input wire logic [1:0] pump_factor_field,
  input wire logic [5:0] contrast_level_field,
  input wire logic column_mirror_bit,
  input wire logic row_order_bit,
  input wire logic all_on_bit,
  input wire logic panel_show_bit,
  input wire logic power_save,
  input wire logic osc_running,
  input wire logic charge_pump_stage_on,
  input wire logic regulator_stage_on,
  input wire logic follower_stage_on,
  input wire logic outputs_grounded,
  input wire logic [1:0] pixel_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_reg, pend_next, cmd, par;
  logic [7:0] op_reg, op_next;
  assign cmd = wr_strobe && !cmd_data_select && !three_wire_mode && !pend_reg;
  assign par = wr_strobe && !three_wire_mode && pend_reg;
  // Tracks whether the next four-wire strobe is a parameter byte
  always_comb begin
    pend_next = pend_reg;
    op_next = op_reg;
    if (three_wire_mode || par) begin
      pend_next = 1'b0;
    end else if (cmd) begin
      op_next = wr_byte;
      pend_next = wr_byte[7:4] == 4'h4 || wr_byte == 8'h81 || wr_byte[7:3] == 5'h11
        || wr_byte == 8'he8;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      op_reg <= 8'h00;
    end else begin
      pend_reg <= pend_next;
      op_reg <= op_next;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_line_par;
    par && op_reg[7:2] == 6'h12;
  endsequence
  sequence s_save_enter;
    cmd && wr_byte == 8'ha9;
  endsequence
  chk_line_keep: assert property (s_line_par ##0 (wr_byte < 8'h10 || wr_byte > 8'h80) |=>
    $stable(line_count)) else $error("line count changed on invalid value");
  chk_line_load: assert property (s_line_par ##0 (wr_byte >= 8'h10 && wr_byte <= 8'h80) |=>
    line_count == $past(wr_byte)) else $error("line count not loaded");
  chk_inv_load: assert property (par && op_reg[7:2] == 6'h13 |=>
    inversion_line_field == $past(wr_byte[4:0])) else $error("inversion field not loaded");
  chk_inv_cancel: assert property (cmd && wr_byte == 8'he4 |=>
    inversion_line_field == 5'h00) else $error("inversion not cancelled");
  chk_bias_load: assert property (cmd && wr_byte[7:3] == 5'h0a |=>
    bias_select_field == $past(wr_byte[2:0])) else $error("bias not loaded");
  chk_pump_load: assert property (cmd && wr_byte[7:2] == 6'h19 |=>
    pump_factor_field == $past(wr_byte[1:0])) else $error("pump factor not loaded");
  chk_contrast_load: assert property (par && op_reg == 8'h81 |=>
    contrast_level_field == $past(wr_byte[5:0])) else $error("contrast not loaded");
  chk_mirror_load: assert property (cmd && wr_byte[7:1] == 7'h50 |=>
    column_mirror_bit == $past(wr_byte[0])) else $error("mirror bit not loaded");
  chk_row_load: assert property (cmd && wr_byte[7:4] == 4'hc |=>
    row_order_bit == $past(wr_byte[3])) else $error("row order not loaded");
  chk_save_stages: assert property (s_save_enter |=> power_save ##1 (!osc_running
    && outputs_grounded && !charge_pump_stage_on && !regulator_stage_on && !follower_stage_on))
    else $error("power save state wrong");
  chk_save_exit: assert property (cmd && wr_byte == 8'he1 |=> !power_save ##1
    !outputs_grounded) else $error("power save not left");
  chk_panel_blank: assert property (!panel_show_bit |=> pixel_level == 2'h0)
    else $error("pixel driven with panel off");
  chk_all_on_lit: assert property (all_on_bit && panel_show_bit && !power_save |=>
    pixel_level == 2'h3) else $error("all-on pixel not lit");
endmodule

// ===== tb/lcd_display_setting_decoder_tb_top.sv
// Testbench joining the APB host and the setting decoder
module lcd_display_setting_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] pixel_code = 2'h1, pixel_level, pump_factor_field;
  logic [6:0] ram_column = 7'h05, scan_step = 7'h00, column_driver_line, row_driver_line;
  logic [7:0] line_count, data_byte, last_data = 8'h00;
  logic [4:0] inversion_line_field;
  logic [2:0] bias_select_field;
  logic [5:0] contrast_level_field;
  logic column_mirror_bit, row_order_bit, all_on_bit, invert_gray_bit, panel_show_bit;
  logic power_save, osc_running, charge_pump_stage_on, regulator_stage_on, follower_stage_on;
  logic outputs_grounded, data_valid;
  int errors = 0, total_checks = 0, nvalid = 0, n0, nsent = 0;
  // Opcode, parameter, two-byte flag and field select, expected field
  logic [31:0] rows [28] = '{32'h480f1080, 32'h48101010, 32'h48811010, 32'h487f107f,
    32'h48801080, 32'h4cff111f, 32'he4000100, 32'h4f051105, 32'h50000200, 32'h53000203,
    32'h57000207, 32'h64000300, 32'h67000303, 32'h65000301, 32'h81ff143f, 32'h81a51425,
    32'ha1000501, 32'ha0000500, 32'ha1000501, 32'hc8000601, 32'hc7000600, 32'hcf000601,
    32'ha5000701, 32'ha4000700, 32'ha7000801, 32'haf000901, 32'hae000900, 32'hab000a01};
  lcd_cmd_if link ();
  lcd_cmd_host lcd_cmd_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link));
  lcd_setting_decoder lcd_setting_decoder_i (.pclk, .presetn, .link(link), .pixel_code,
    .ram_column, .scan_step, .line_count, .inversion_line_field, .bias_select_field,
    .pump_factor_field, .contrast_level_field, .column_mirror_bit, .row_order_bit,
    .all_on_bit, .invert_gray_bit, .panel_show_bit, .power_save, .osc_running,
    .charge_pump_stage_on, .regulator_stage_on, .follower_stage_on, .outputs_grounded,
    .pixel_level, .column_driver_line, .row_driver_line, .data_valid, .data_byte);
  lcd_setting_asserts lcd_setting_asserts_i (.pclk, .presetn, .wr_strobe(link.wr_strobe),
    .cmd_data_select(link.cmd_data_select), .wr_byte(link.wr_byte),
    .three_wire_mode(link.three_wire_mode), .line_count, .inversion_line_field,
    .bias_select_field, .pump_factor_field, .contrast_level_field, .column_mirror_bit,
    .row_order_bit, .all_on_bit, .panel_show_bit, .power_save, .osc_running,
    .charge_pump_stage_on, .regulator_stage_on, .follower_stage_on, .outputs_grounded,
    .pixel_level);
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (data_valid === 1'b1) begin
      nvalid <= nvalid + 1;
      last_data <= data_byte;
    end
  end
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    if (w && (a == 8'h00 || a == 8'h04)) nsent++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task cmd(input logic [7:0] b);
    apb(1'b1, 8'h00, {24'h0, b});
  endtask
  task settle;
    repeat (3) @(posedge pclk);
  endtask
  function logic [7:0] field(input logic [3:0] s);
    case (s)
      4'h0: return line_count;
      4'h1: return {3'h0, inversion_line_field};
      4'h2: return {5'h0, bias_select_field};
      4'h3: return {6'h0, pump_factor_field};
      4'h4: return {2'h0, contrast_level_field};
      4'h5: return {7'h0, column_mirror_bit};
      4'h6: return {7'h0, row_order_bit};
      4'h7: return {7'h0, all_on_bit};
      4'h8: return {7'h0, invert_gray_bit};
      4'h9: return {7'h0, panel_show_bit};
      default: return {7'h0, osc_running};
    endcase
  endfunction
  initial begin
    #200000;
    errors++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      cmd(rows[i][31:24]);
      if (rows[i][12]) cmd(rows[i][23:16]);
      settle;
      chk("setting", {24'h0, field(rows[i][11:8])}, {24'h0, rows[i][7:0]});
    end
    cmd(8'he2);
    settle;
    chk("soft contrast", {26'h0, contrast_level_field}, 32'h20);
    chk("soft kept", {line_count, inversion_line_field, bias_select_field, pump_factor_field,
      column_mirror_bit, row_order_bit, invert_gray_bit, osc_running}, 32'h0020_0bdf);
    cmd(8'haf);
    settle;
    chk("pixel", {pixel_level, column_driver_line, row_driver_line}, {2'h2, 7'h7a, 7'h7f});
    cmd(8'ha5);
    settle;
    chk("all on", {30'h0, pixel_level}, 32'h3);
    cmd(8'hae);
    cmd(8'h52);
    settle;
    chk("panel off", {pixel_level, bias_select_field}, {2'h0, 3'h2});
    cmd(8'h2d);
    cmd(8'ha9);
    settle;
    chk("save", {osc_running, charge_pump_stage_on, regulator_stage_on, follower_stage_on,
      outputs_grounded}, 32'h01);
    cmd(8'he1);
    settle;
    chk("resume", {osc_running, charge_pump_stage_on, regulator_stage_on, follower_stage_on,
      outputs_grounded}, 32'h1a);
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("mode", rd, 32'h1);
    n0 = nvalid;
    cmd(8'he8);
    cmd(8'h01);
    cmd(8'ha0);
    cmd(8'h57);
    settle;
    chk("three wire", {16'(nvalid - n0), 7'h0, column_mirror_bit, last_data}, 32'h201_57);
    cmd(8'ha0);
    settle;
    chk("after data", {31'h0, column_mirror_bit}, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    n0 = nvalid;
    cmd(8'he8);
    cmd(8'h01);
    cmd(8'ha1);
    apb(1'b1, 8'h04, 32'h3c);
    settle;
    chk("four wire", {16'(nvalid - n0), 7'h0, column_mirror_bit, last_data}, 32'h101_3c);
    apb(1'b0, 8'h08, 32'h0);
    chk("sent count", rd, nsent);
    cmd(8'h81);
    cmd(8'h11);
    cmd(8'h48);
    cmd(8'h40);
    settle;
    chk("before reset", {line_count, 2'h0, contrast_level_field}, {8'h40, 8'h11});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk("hw reset", {line_count, inversion_line_field, bias_select_field, pump_factor_field,
      contrast_level_field}, 32'h800720);
    chk("hw bits", {column_mirror_bit, row_order_bit, all_on_bit, invert_gray_bit,
      panel_show_bit, power_save, osc_running}, 32'h0);
    test_done;
  end
endmodule
